// *** inc/pps_pkg.sv ***
// Purpose: constants and carrier types for the port power / over-current source selector
// Assumes: 32-bit classic Wishbone, byte addresses, 100 MHz core clock
// Notes: registers are 8 bits wide and sit in the low byte of each word
package pps_pkg;

  // ==========================================================
  // register map (byte addresses)
  localparam logic [15:0] PPS_PORT6_POWER_SOURCE_CFG_OFS = 16'h3c14;
  localparam logic [15:0] PPS_PORT7_POWER_SOURCE_CFG_OFS = 16'h3c18;
  localparam logic [15:0] PPS_PORT1_OC_SOURCE_CFG_OFS = 16'h3c20;
  localparam logic [15:0] PPS_PORT2_OC_SOURCE_CFG_OFS = 16'h3c24;
  localparam logic [15:0] PPS_PORT_STATUS_OFS = 16'h3c40;

  // ==========================================================
  // field positions
  localparam int PPS_COMBINED_BIT = 7;
  localparam int PPS_RSVD_BIT = 6;
  localparam int PPS_DISABLED_BIT = 5;
  localparam int PPS_FIXED_DEV_BIT = 4;
  localparam int PPS_SRC_LSB = 0;
  localparam int PPS_SRC_W = 4;

  // ==========================================================
  // reset values and write mask
  localparam logic [7:0] PPS_POWER_CFG_RST = 8'h00;
  localparam logic [7:0] PPS_OC_CFG_RST = 8'h00;
  localparam logic [7:0] PPS_POWER_CFG_WMASK = 8'hbf;

  // ==========================================================
  // source codes
  localparam logic [3:0] PPS_PWR_OFF = 4'h0;
  localparam logic [3:0] PPS_PWR_USB2 = 4'h1;
  localparam logic [3:0] PPS_PWR_USB3 = 4'h2;
  localparam logic [3:0] PPS_PWR_EITHER = 4'h3;
  localparam logic [3:0] PPS_PWR_GPIO = 4'h4;
  localparam logic [3:0] PPS_OC_DISABLED = 4'h0;
  localparam logic [3:0] PPS_OC_PIN = 4'h1;
  localparam logic [3:0] PPS_OC_GPIO = 4'h2;
  localparam logic [3:0] PPS_OC_FORCE = 4'hf;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [15:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } pps_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } pps_wb_rsp_t;

endpackage

// *** hdl/pps_port_source_sel.sv ***
// Purpose: per-port power and over-current source selection registers
// Assumes: classic Wishbone slave, synchronous active-high reset
// Notes: ack comes one cycle after the request; unmapped reads return zero
//
// How it works
// (R1) bit 7 of a power select register picks shared (1) or separate (0) power/sense pins.
// (R2) bit 5 of a power select register marks the port permanently disabled.
// (R3) bit 4 of a power select register marks a permanently attached device.
// (R4) power source 0000b keeps power off, 0001b follows USB2 port power.
// (R5) power source 0010b follows USB3 port power, 0011b is on when either is on.
// (R6) power source 0100b follows the port's GPIO; other codes are reserved.
// (R7) over-current source 0000b marks the port disabled.
// (R8) over-current source 0001b uses the sense pin, 0010b uses a GPIO.
// (R9) over-current source 1111b forces the indication on; other codes are reserved.
// (R10) software loads these settings once and does not change them in operation.
// (R11) disable, fixed-device and shared-pin bits are set before enumeration.
// (R12) a reserved power code keeps power off, and bit 6 reads zero and ignores writes.
//
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/1ps

module pps_port_source_sel
  import pps_pkg::*;
(
  input wire logic clk_i,                        // core clock
  input wire logic reset_i,                      // sync reset, active high
  input wire pps_wb_req_t wb_req_i,              // wishbone request
  output pps_wb_rsp_t wb_rsp_o,                  // wishbone answer
  input wire logic [1:0] usb2_port_power_i,      // usb2 power state, ports 6/7
  input wire logic [1:0] usb3_port_power_i,      // usb3 power state, ports 6/7
  input wire logic [1:0] power_gpio_i,           // designated gpio, ports 6/7
  input wire logic [1:0] overcurrent_sense_i,    // sense pin, ports 1/2
  input wire logic [1:0] overcurrent_gpio_i,     // sense gpio, ports 1/2
  output logic [1:0] port_power_o,               // power enable, ports 6/7
  output logic [1:0] power_port_disabled_o,      // permanently disabled, ports 6/7
  output logic [1:0] fixed_attached_device_o,    // fixed device, ports 6/7
  output logic [1:0] combined_mode_o,            // shared pins, ports 6/7
  output logic [1:0] overcurrent_o,              // over-current, ports 1/2
  output logic [1:0] oc_port_disabled_o          // disabled by sense cfg, ports 1/2
);

  // ==========================================================
  // source decode
  function automatic logic power_pick(input logic [3:0] src, input logic u2,
                                      input logic u3, input logic gp);
    logic r;
    r = 1'b0;
    unique case (src)
      PPS_PWR_USB2: r = u2;
      PPS_PWR_USB3: r = u3;
      PPS_PWR_EITHER: r = u2 | u3;
      PPS_PWR_GPIO: r = gp;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  function automatic logic oc_pick(input logic [3:0] src, input logic pin, input logic gp);
    logic r;
    r = 1'b0;
    unique case (src)
      PPS_OC_PIN: r = pin;
      PPS_OC_GPIO: r = gp;
      PPS_OC_FORCE: r = 1'b1;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // ==========================================================
  // bus decode
  logic ack_q;
  logic [31:0] rdat_q;
  logic [7:0] pwr_cfg_q [2];
  logic [7:0] oc_cfg_q [2];
  logic [1:0] port_power_q;
  logic [1:0] overcurrent_q;

  wire logic req = wb_req_i.cyc & wb_req_i.stb & ~ack_q;
  wire logic wr_lo = req & wb_req_i.we & wb_req_i.sel[0];
  wire logic hit_p6 = wb_req_i.adr == PPS_PORT6_POWER_SOURCE_CFG_OFS;
  wire logic hit_p7 = wb_req_i.adr == PPS_PORT7_POWER_SOURCE_CFG_OFS;
  wire logic hit_o1 = wb_req_i.adr == PPS_PORT1_OC_SOURCE_CFG_OFS;
  wire logic hit_o2 = wb_req_i.adr == PPS_PORT2_OC_SOURCE_CFG_OFS;
  wire logic hit_st = wb_req_i.adr == PPS_PORT_STATUS_OFS;
  wire logic [1:0] wr_pwr = {wr_lo & hit_p7, wr_lo & hit_p6};
  wire logic [1:0] wr_oc = {wr_lo & hit_o2, wr_lo & hit_o1};
  wire logic [7:0] status_byte = {2'b00, oc_port_disabled_o, overcurrent_q, port_power_q};
  wire logic [7:0] rd_byte = hit_p6 ? pwr_cfg_q[0] :
                             hit_p7 ? pwr_cfg_q[1] :
                             hit_o1 ? oc_cfg_q[0] :
                             hit_o2 ? oc_cfg_q[1] :
                             hit_st ? status_byte : 8'h00;
  wire logic [7:0] pwr_wdata = wb_req_i.dat[7:0] & PPS_POWER_CFG_WMASK; // R12

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q <= req;
      if (req) begin
        rdat_q <= {24'h00_0000, rd_byte};
      end
    end
  end

  assign wb_rsp_o.ack = ack_q;
  assign wb_rsp_o.dat = rdat_q;

  // ==========================================================
  // configuration registers
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pwr_cfg_q[0] <= PPS_POWER_CFG_RST;
      pwr_cfg_q[1] <= PPS_POWER_CFG_RST;
      oc_cfg_q[0] <= PPS_OC_CFG_RST;
      oc_cfg_q[1] <= PPS_OC_CFG_RST;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (wr_pwr[i]) begin
          pwr_cfg_q[i] <= pwr_wdata;
        end
        if (wr_oc[i]) begin
          oc_cfg_q[i] <= wb_req_i.dat[7:0];
        end
      end
    end
  end

  // ==========================================================
  // port power and over-current selection
  logic [1:0] port_power_d;
  logic [1:0] overcurrent_d;

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      port_power_d[i] = ~pwr_cfg_q[i][PPS_DISABLED_BIT] & // R2
        power_pick(pwr_cfg_q[i][PPS_SRC_LSB +: PPS_SRC_W], usb2_port_power_i[i],
                   usb3_port_power_i[i], power_gpio_i[i]); // R4 R5 R6 R12
      overcurrent_d[i] = oc_pick(oc_cfg_q[i][PPS_SRC_LSB +: PPS_SRC_W],
                                 overcurrent_sense_i[i], overcurrent_gpio_i[i]); // R8 R9
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      port_power_q <= 2'h0;
      overcurrent_q <= 2'h0;
    end else begin
      port_power_q <= port_power_d;
      overcurrent_q <= overcurrent_d;
    end
  end

  assign port_power_o = port_power_q;
  assign overcurrent_o = overcurrent_q;

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      combined_mode_o[i] = pwr_cfg_q[i][PPS_COMBINED_BIT]; // R1
      power_port_disabled_o[i] = pwr_cfg_q[i][PPS_DISABLED_BIT]; // R2
      fixed_attached_device_o[i] = pwr_cfg_q[i][PPS_FIXED_DEV_BIT]; // R3
      oc_port_disabled_o[i] = oc_cfg_q[i][PPS_SRC_LSB +: PPS_SRC_W] == PPS_OC_DISABLED; // R7
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  wire logic [3:0] src6 = pwr_cfg_q[0][3:0];
  wire logic [3:0] ocs1 = oc_cfg_q[0][3:0];
  wire logic en6 = ~pwr_cfg_q[0][PPS_DISABLED_BIT];
  wire logic [3:0] src7 = pwr_cfg_q[1][PPS_SRC_LSB +: PPS_SRC_W];
  wire logic [3:0] ocs2 = oc_cfg_q[1][PPS_SRC_LSB +: PPS_SRC_W];
  wire logic en7 = ~pwr_cfg_q[1][PPS_DISABLED_BIT];
  wire logic oc1_rsvd = ~(ocs1 inside {PPS_OC_DISABLED, PPS_OC_PIN, PPS_OC_GPIO, PPS_OC_FORCE});
  wire logic oc2_rsvd = ~(ocs2 inside {PPS_OC_DISABLED, PPS_OC_PIN, PPS_OC_GPIO, PPS_OC_FORCE});

  sequence s_write_p6;
    wr_lo && hit_p6;
  endsequence

  sequence s_write_p7;
    wr_lo && hit_p7;
  endsequence

  sequence s_oc1_enabled;
    wr_lo && hit_o1 && wb_req_i.dat[3:0] != PPS_OC_DISABLED;
  endsequence

  sequence s_oc2_cleared;
    wr_lo && hit_o2 && wb_req_i.dat[3:0] == PPS_OC_DISABLED;
  endsequence

  property p_combined_write;
    s_write_p6 |=> combined_mode_o[0] == $past(wb_req_i.dat[7]);
  endproperty
  a_combined_write: assert property (p_combined_write) else $error("shared pin bit"); // R1

  property p_disabled_off;
    $past(pwr_cfg_q[0][PPS_DISABLED_BIT]) |-> !port_power_o[0];
  endproperty
  a_disabled_off: assert property (p_disabled_off) else $error("disabled port powered"); // R2

  property p_fixed_write;
    s_write_p6 |=> fixed_attached_device_o[0] == $past(wb_req_i.dat[4]);
  endproperty
  a_fixed_write: assert property (p_fixed_write) else $error("fixed device bit"); // R3

  property p_src_usb2;
    (src6 == PPS_PWR_USB2 && en6) |=> port_power_o[0] == $past(usb2_port_power_i[0]);
  endproperty
  a_src_usb2: assert property (p_src_usb2) else $error("usb2 follow"); // R4

  property p_src_off;
    src6 == PPS_PWR_OFF |=> !port_power_o[0];
  endproperty
  a_src_off: assert property (p_src_off) else $error("power off code"); // R4

  property p_src_either;
    (src6 == PPS_PWR_EITHER && en6) |=>
      port_power_o[0] == ($past(usb2_port_power_i[0]) | $past(usb3_port_power_i[0]));
  endproperty
  a_src_either: assert property (p_src_either) else $error("usb2 or usb3"); // R5

  property p_src_gpio;
    (src6 == PPS_PWR_GPIO && en6) |=> port_power_o[0] == $past(power_gpio_i[0]);
  endproperty
  a_src_gpio: assert property (p_src_gpio) else $error("gpio follow"); // R6

  property p_oc_disabled;
    (wr_lo && hit_o1 && wb_req_i.dat[3:0] == PPS_OC_DISABLED) |=>
      oc_port_disabled_o[0] ##1 !overcurrent_o[0];
  endproperty
  a_oc_disabled: assert property (p_oc_disabled) else $error("sense disable"); // R7

  property p_oc_pin;
    ocs1 == PPS_OC_PIN |=> overcurrent_o[0] == $past(overcurrent_sense_i[0]);
  endproperty
  a_oc_pin: assert property (p_oc_pin) else $error("sense pin"); // R8

  property p_oc_force;
    ocs1 == PPS_OC_FORCE [*2] |-> overcurrent_o[0];
  endproperty
  a_oc_force: assert property (p_oc_force) else $error("forced sense"); // R9

  property p_reserved_off;
    (src6 > PPS_PWR_GPIO) |=> !port_power_o[0];
  endproperty
  a_reserved_off: assert property (p_reserved_off) else $error("reserved code powered"); // R12

  property p_bit6_zero;
    (req && !wb_req_i.we && (hit_p6 || hit_p7)) |=> wb_rsp_o.ack && !wb_rsp_o.dat[6];
  endproperty
  a_bit6_zero: assert property (p_bit6_zero) else $error("bit 6 not zero"); // R12

  property p_src_usb3;
    (src6 == PPS_PWR_USB3 && en6) |=> port_power_o[0] == $past(usb3_port_power_i[0]);
  endproperty
  a_src_usb3: assert property (p_src_usb3) else $error("usb3 follow"); // R5

  property p_combined_write7;
    s_write_p7 |=> combined_mode_o[1] == $past(wb_req_i.dat[PPS_COMBINED_BIT]);
  endproperty
  a_combined_write7: assert property (p_combined_write7) else $error("port 7 shared pin"); // R1

  property p_disabled_write7;
    s_write_p7 |=> power_port_disabled_o[1] == $past(wb_req_i.dat[PPS_DISABLED_BIT]);
  endproperty
  a_disabled_write7: assert property (p_disabled_write7) else $error("port 7 disable"); // R2

  property p_disabled_off7;
    $past(pwr_cfg_q[1][PPS_DISABLED_BIT]) |-> !port_power_o[1];
  endproperty
  a_disabled_off7: assert property (p_disabled_off7) else $error("port 7 powered"); // R2

  property p_fixed_write7;
    s_write_p7 |=> fixed_attached_device_o[1] == $past(wb_req_i.dat[PPS_FIXED_DEV_BIT]);
  endproperty
  a_fixed_write7: assert property (p_fixed_write7) else $error("port 7 fixed device"); // R3

  property p_src_off7;
    src7 == PPS_PWR_OFF |=> !port_power_o[1];
  endproperty
  a_src_off7: assert property (p_src_off7) else $error("port 7 off code"); // R4

  property p_src_usb2_7;
    (src7 == PPS_PWR_USB2 && en7) |=> port_power_o[1] == $past(usb2_port_power_i[1]);
  endproperty
  a_src_usb2_7: assert property (p_src_usb2_7) else $error("port 7 usb2 follow"); // R4

  property p_src_usb3_7;
    (src7 == PPS_PWR_USB3 && en7) |=> port_power_o[1] == $past(usb3_port_power_i[1]);
  endproperty
  a_src_usb3_7: assert property (p_src_usb3_7) else $error("port 7 usb3 follow"); // R5

  property p_src_either7;
    (src7 == PPS_PWR_EITHER && en7) |=>
      port_power_o[1] == ($past(usb2_port_power_i[1]) | $past(usb3_port_power_i[1]));
  endproperty
  a_src_either7: assert property (p_src_either7) else $error("port 7 usb2 or usb3"); // R5

  property p_src_gpio7;
    (src7 == PPS_PWR_GPIO && en7) |=> port_power_o[1] == $past(power_gpio_i[1]);
  endproperty
  a_src_gpio7: assert property (p_src_gpio7) else $error("port 7 gpio follow"); // R6

  property p_reserved_off7;
    (src7 > PPS_PWR_GPIO) |=> !port_power_o[1];
  endproperty
  a_reserved_off7: assert property (p_reserved_off7) else $error("port 7 reserved code"); // R12

  property p_oc_gpio;
    ocs1 == PPS_OC_GPIO |=> overcurrent_o[0] == $past(overcurrent_gpio_i[0]);
  endproperty
  a_oc_gpio: assert property (p_oc_gpio) else $error("sense gpio"); // R8

  property p_oc_enabled;
    s_oc1_enabled |=> !oc_port_disabled_o[0];
  endproperty
  a_oc_enabled: assert property (p_oc_enabled) else $error("sense port flagged"); // R7

  property p_oc_reserved;
    oc1_rsvd |=> !overcurrent_o[0];
  endproperty
  a_oc_reserved: assert property (p_oc_reserved) else $error("reserved sense code"); // R9

  property p_oc_disabled2;
    s_oc2_cleared |=> oc_port_disabled_o[1] ##1 !overcurrent_o[1];
  endproperty
  a_oc_disabled2: assert property (p_oc_disabled2) else $error("port 2 sense disable"); // R7

  property p_oc_pin2;
    ocs2 == PPS_OC_PIN |=> overcurrent_o[1] == $past(overcurrent_sense_i[1]);
  endproperty
  a_oc_pin2: assert property (p_oc_pin2) else $error("port 2 sense pin"); // R8

  property p_oc_gpio2;
    ocs2 == PPS_OC_GPIO |=> overcurrent_o[1] == $past(overcurrent_gpio_i[1]);
  endproperty
  a_oc_gpio2: assert property (p_oc_gpio2) else $error("port 2 sense gpio"); // R8

  property p_oc_force2;
    (ocs2 == PPS_OC_FORCE) [*2] |-> overcurrent_o[1];
  endproperty
  a_oc_force2: assert property (p_oc_force2) else $error("port 2 forced sense"); // R9

  property p_oc_reserved2;
    oc2_rsvd |=> !overcurrent_o[1];
  endproperty
  a_oc_reserved2: assert property (p_oc_reserved2) else $error("port 2 reserved sense"); // R9

  property p_bit6_write;
    (wr_lo && (hit_p6 || hit_p7)) |=>
      !pwr_cfg_q[0][PPS_RSVD_BIT] && !pwr_cfg_q[1][PPS_RSVD_BIT];
  endproperty
  a_bit6_write: assert property (p_bit6_write) else $error("bit 6 stored"); // R12

endmodule

// *** dv/pps_sensor_model.sv ***
// Purpose: over-current sensor pair facing the port source selector
// Assumes: one core clock
// Notes: raises sense only when the bench commands a fault
`timescale 1ns/1ps

module pps_sensor_model (
  input wire logic clk_i,         // core clock
  input wire logic [1:0] fault_i, // commanded over-current, ports 1/2
  output logic [1:0] sense_o      // sense pins, high = over-current
);
  // ==========================================================
  // sensor lags the fault by one cycle, like a real comparator
  always_ff @(posedge clk_i) begin
    sense_o <= fault_i;
  end
endmodule

// *** dv/tb.sv ***
// Purpose: self-checking bench for the port power / over-current selector
// Assumes: ack one cycle after a taken request, outputs registered once
// Notes: each pass resets, loads the config once, then moves the inputs
`timescale 1ns/1ps

module tb;
  import pps_pkg::*;
  logic clk_i, reset_i;
  pps_wb_req_t wb_req_i;
  pps_wb_rsp_t wb_rsp_o;
  logic [1:0] u2, u3, pg, og, fault, sense, pw, pdis, fix, comb, oc, ocd, ep, eo;
  logic [31:0] seed = 32'h0000_093c;
  logic [31:0] d;
  int n_errors = 0;
  int n_tests = 0;
  int pc[2];
  int ocf[2];
  logic [15:0] adr[6] = '{PPS_PORT6_POWER_SOURCE_CFG_OFS, PPS_PORT7_POWER_SOURCE_CFG_OFS,
    PPS_PORT1_OC_SOURCE_CFG_OFS, PPS_PORT2_OC_SOURCE_CFG_OFS, PPS_PORT_STATUS_OFS, 16'h3c1c};

  pps_port_source_sel i_pps_port_source_sel (.clk_i(clk_i), .reset_i(reset_i),
    .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o), .usb2_port_power_i(u2),
    .usb3_port_power_i(u3), .power_gpio_i(pg), .overcurrent_sense_i(sense),
    .overcurrent_gpio_i(og), .port_power_o(pw), .power_port_disabled_o(pdis),
    .fixed_attached_device_o(fix), .combined_mode_o(comb), .overcurrent_o(oc),
    .oc_port_disabled_o(ocd));
  pps_sensor_model i_pps_sensor_model (.clk_i(clk_i), .fault_i(fault), .sense_o(sense));

  // ==========================================================
  // helpers
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic exp_pw(int c, logic a, logic b, logic g);
    if (c[5])
      return 1'b0;
    case (c[3:0])
      1: return a;
      2: return b;
      3: return a | b;
      4: return g;
      default: return 1'b0;
    endcase
  endfunction

  task automatic tally_and_finish();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] ex);
    n_tests++;
    if (seen !== ex) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, ex, seen);
    end
  endtask

  task automatic wb(logic we, logic [15:0] a, logic [7:0] wd, logic s, output logic [31:0] rd);
    int n;
    n = 0;
    wb_req_i <= '{1'b1, 1'b1, we, a, {3'b000, s}, {24'h00_0000, wd}};
    @(posedge clk_i);
    while (wb_rsp_o.ack !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    if (n == 20) begin
      n_errors++;
      tally_and_finish();
    end
    rd = wb_rsp_o.dat;
    wb_req_i.cyc <= 1'b0;
    wb_req_i.stb <= 1'b0;
    @(posedge clk_i);
  endtask

  // ==========================================================
  // clock, watchdog, main sequence
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  initial begin
    repeat (50000) @(posedge clk_i);
    n_errors++;
    tally_and_finish();
  end

  initial begin
    reset_i = 1'b1;
    wb_req_i = '0;
    {u2, u3, pg, og, fault} = '0;
    repeat (4) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    for (int r = 0; r < 6; r++) begin
      if (r > 3)
        wb(1'b1, adr[r], 8'hff, 1'b1, d);
      wb(1'b0, adr[r], 8'h00, 1'b0, d);
      chk("reset read", d, (r == 4) ? 32'h0000_0030 : 32'h0000_0000);
    end
    for (int it = 0; it < 32; it++) begin
      reset_i <= 1'b1;
      @(posedge clk_i);
      reset_i <= 1'b0;
      @(posedge clk_i);
      pc[0] = (rnd() & 32'hf0) | (it & 15);
      pc[1] = (rnd() & 32'hf0) | ((it + 5) & 15);
      ocf[0] = (rnd() & 32'hf0) | (it & 15);
      ocf[1] = (rnd() & 32'hf0) | ((it + 9) & 15);
      wb(1'b1, adr[0], 8'hff, 1'b0, d);
      wb(1'b0, adr[0], 8'h00, 1'b0, d);
      chk("sel0 write", d, 32'h0000_0000);
      for (int r = 0; r < 4; r++)
        wb(1'b1, adr[r], (r < 2) ? pc[r][7:0] : ocf[r - 2][7:0], 1'b1, d);
      for (int r = 0; r < 4; r++) begin
        wb(1'b0, adr[r], 8'h00, 1'b0, d);
        chk("readback", d, (r < 2) ? (pc[r] & 32'hbf) : ocf[r - 2]);
      end
      for (int k = 0; k < 4; k++) begin
        d = rnd();
        {u2, u3, pg, og, fault} <= d[9:0];
        repeat (3) @(posedge clk_i);
        #1;
        for (int p = 0; p < 2; p++) begin
          ep[p] = exp_pw(pc[p], u2[p], u3[p], pg[p]);
          eo[p] = (ocf[p][3:0] == 1) ? fault[p] : (ocf[p][3:0] == 2) ? og[p] :
            (ocf[p][3:0] == 15);
          chk("combined", comb[p], pc[p][7]);
          chk("disabled", pdis[p], pc[p][5]);
          chk("fixed dev", fix[p], pc[p][4]);
          chk("oc off", ocd[p], ocf[p][3:0] == 0);
        end
        chk("port power", pw, ep);
        chk("overcurrent", oc, eo);
        @(posedge clk_i);
        wb(1'b0, adr[4], 8'h00, 1'b0, d);
        chk("status", d, {26'h0, (ocf[1][3:0] == 0), (ocf[0][3:0] == 0), eo, ep});
      end
    end
    tally_and_finish();
  end
endmodule
